// ==== verilog/ffpc_pkg.sv ====
// constants, types and carriers of the flash fetch and row program controller
// assumes one system clock shared by the cpu core, the register port and the array
package ffpc_pkg;
    localparam int REG_AW = 16;
    localparam int FETCH_AW = 15;
    localparam int COL_IDX_W = 13;
    localparam logic [REG_AW-1:0] OFS_PAGE = 16'hff01;
    localparam logic [REG_AW-1:0] OFS_ROW = 16'hff02;
    localparam logic [REG_AW-1:0] OFS_COL = 16'hff03;
    localparam logic [REG_AW-1:0] OFS_MODE = 16'hff04;
    localparam logic [REG_AW-1:0] OFS_EXEC = 16'hff05;
    localparam logic [REG_AW-1:0] OFS_DATA0 = 16'hff10;
    localparam logic [REG_AW-1:0] OFS_DATA3 = 16'hff13;
    localparam logic [REG_AW-1:0] OFS_READ_TIMING = 16'hff20;
    localparam logic [REG_AW-1:0] OFS_PROGRAM_WAIT = 16'hff23;
    localparam logic [REG_AW-1:0] PROT_CODE_ADDR = 16'ha200;
    localparam int FAST_BIT = 0;
    localparam int WAIT_FLAG_BIT = 4;
    localparam int WAIT_IE_BIT = 0;
    localparam int EXEC_BIT = 0;
    localparam int HALF_BIT = 4;
    localparam logic FAST_RESET = 1'h1;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [3:0] CMD_NORMAL = 4'h0;
    localparam logic [3:0] CMD_READ_MAIN = 4'h4;
    localparam logic [3:0] CMD_PGM_MAIN = 4'h5;
    localparam logic [3:0] CMD_READ_INFO = 4'h8;
    localparam logic [3:0] CMD_PGM_INFO = 4'h9;
    localparam logic [4:0] LAST_COL = 5'h1f;
    localparam logic [2:0] INFO_USER_ROW = 3'h5;
    localparam logic [1:0] ACC_SLOW = 2'h1;
    localparam logic [1:0] ACC_FAST = 2'h2;
    localparam logic [1:0] PF_OFS_FAST = 2'h2;
    localparam logic [1:0] PF_OFS_SLOW = 2'h3;

    typedef enum logic [1:0] {FF_IDLE, FF_ACC, FF_CAP} ffpc_fstate_t;
    typedef enum logic [1:0] {FK_INSTR, FK_DATA, FK_PREF, FK_ROWRD} ffpc_kind_t;

    // register port from software
    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ffpc_reg_req_t;

    // cpu fetch request, held until taken in an idle cycle
    typedef struct packed {
        logic req;
        logic isData;
        logic [FETCH_AW-1:0] addr;
    } ffpc_fetch_req_t;

    // drive toward the flash array macro
    typedef struct packed {
        logic rdEn;
        logic [COL_IDX_W-1:0] rdCol;
        logic rdInfo;
        logic pgmStart;
        logic [COL_IDX_W-1:0] pgmCol;
        logic pgmInfo;
        logic pgmHalf;
        logic [31:0] pgmData;
    } ffpc_array_out_t;
endpackage

// ==== verilog/flash_fetch_program_ctrl.sv ====
// flash fetch controller with row program data, read timing and program wait control
// assumes array read data is valid in the cycle after the last read enable cycle,
// program done is a one-cycle pulse, and all inputs share clk
`timescale 1ns/1ns
`default_nettype none
module flash_fetch_program_ctrl
    import ffpc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire ffpc_reg_req_t regReq,
    output logic [7:0] regRdData,
    input wire ffpc_fetch_req_t fetchReq,
    output logic fetchBusy,
    output logic fetchValid,
    output logic [7:0] fetchByte,
    output ffpc_array_out_t arrayOut,
    input wire logic [31:0] arrayRdData,
    input wire logic arrayPgmDone,
    input wire logic protLevel2,
    input wire logic codeInFlash,
    input wire logic eraseReq,
    input wire logic eraseInfo,
    input wire logic eraseDone,
    output logic eraseGrant,
    output logic eraseRefused,
    output logic columnWaitIrq
);
    typedef struct packed {
        ffpc_fstate_t st;
        ffpc_kind_t kind;
        logic [1:0] cnt;
        logic fastMode;
        logic fastReg;
        logic [4:0] page;
        logic [2:0] row;
        logic [4:0] col;
        logic [3:0] cmd;
        logic half;
        logic exec;
        logic [3:0][7:0] rowData;
        logic waitFlag;
        logic waitIe;
        logic pgmBusy;
        logic [1:0] ibValid;
        logic [1:0][COL_IDX_W-1:0] ibTag;
        logic [1:0][31:0] ibData;
        logic ibLru;
        logic dbValid;
        logic [COL_IDX_W-1:0] dbTag;
        logic [31:0] dbData;
        logic pfPending;
        logic [COL_IDX_W-1:0] pfTag;
        logic [FETCH_AW-1:0] reqAddr;
        logic [7:0] rdData;
        logic busy;
        logic valid;
        logic [7:0] outByte;
        ffpc_array_out_t arr;
        logic grant;
        logic refuse;
        logic irq;
    } ffpc_state_t;

    ffpc_state_t state_reg;
    ffpc_state_t state_next;

    // little-endian byte pick inside a column
    function automatic logic [7:0] pickByte(input logic [31:0] w, input logic [1:0] ofs);
        logic [7:0] b;
        b = 8'h00;
        unique case (ofs)
            2'h0: b = w[7:0];
            2'h1: b = w[15:8];
            2'h2: b = w[23:16];
            2'h3: b = w[31:24];
        endcase
        return b;
    endfunction

    logic [COL_IDX_W-1:0] reqCol;
    logic [1:0] reqOfs;
    logic ibHit0;
    logic ibHit1;
    logic dbHit;
    logic [COL_IDX_W-1:0] curCol;
    logic isPgmCmd;
    logic isReadCmd;
    logic pgmAllowed;
    logic trigWrite;
    logic colDone;

    // lookup of the incoming cpu address against both buffers
    assign reqCol = fetchReq.addr[FETCH_AW-1:2];
    assign reqOfs = fetchReq.addr[1:0];
    assign ibHit0 = state_reg.ibValid[0] && (state_reg.ibTag[0] == reqCol);
    assign ibHit1 = state_reg.ibValid[1] && (state_reg.ibTag[1] == reqCol);
    assign dbHit = state_reg.dbValid && (state_reg.dbTag == reqCol);
    // column index n = 256 page + 32 row + column, byte 4n.. at row data 0..3
    assign curCol = {state_reg.page, state_reg.row, state_reg.col};
    assign isPgmCmd = (state_reg.cmd == CMD_PGM_MAIN) || (state_reg.cmd == CMD_PGM_INFO);
    assign isReadCmd = (state_reg.cmd == CMD_READ_MAIN) || (state_reg.cmd == CMD_READ_INFO);

    // protection: info rows 5..7 stay user area, rows 0..3 stay locked, row 4 with the protection code locks at level two only
    always_comb begin
        if (state_reg.cmd[3]) begin
            pgmAllowed = protLevel2 ? (state_reg.row >= INFO_USER_ROW) : state_reg.row[2];
        end else begin
            pgmAllowed = !protLevel2 || codeInFlash;
        end
    end

    assign trigWrite = regReq.wr && (regReq.addr == OFS_DATA3) && state_reg.exec && isPgmCmd
        && !state_reg.pgmBusy;
    // a column in flight ends on the array's done pulse; a blocked column
    // never reaches the array and is finished by the trigger cycle itself
    assign colDone = state_reg.pgmBusy && arrayPgmDone;

    always_comb begin
        logic prefOk;
        logic [COL_IDX_W-1:0] nextCol;
        logic deliver;
        logic [1:0] dOfs;
        logic [COL_IDX_W-1:0] dCol;
        logic blocked;
        logic instrAns;
        prefOk = 1'b0;
        nextCol = '0;
        deliver = 1'b0;
        dOfs = 2'h0;
        dCol = '0;
        blocked = 1'b0;
        instrAns = 1'b0;
        state_next = state_reg;
        state_next.valid = 1'b0;
        state_next.arr.pgmStart = 1'b0;
        state_next.grant = 1'b0;
        state_next.refuse = 1'b0;

        // register writes; address and mode fields only move while stopped
        if (regReq.wr) begin
            unique case (regReq.addr)
                OFS_PAGE: if (!state_reg.exec) state_next.page = regReq.wdata[4:0];
                OFS_ROW: if (!state_reg.exec) state_next.row = regReq.wdata[2:0];
                OFS_COL: if (!state_reg.exec) state_next.col = regReq.wdata[4:0];
                OFS_MODE: begin
                    if (!state_reg.exec) begin
                        state_next.cmd = regReq.wdata[3:0];
                        state_next.half = regReq.wdata[HALF_BIT];
                    end
                end
                OFS_EXEC: begin
                    if (regReq.wdata[EXEC_BIT] && state_reg.cmd != CMD_NORMAL) begin
                        state_next.exec = 1'b1;
                    end else if (!regReq.wdata[EXEC_BIT]) begin
                        state_next.exec = 1'b0;
                        state_next.waitFlag = 1'b0;
                    end
                end
                OFS_READ_TIMING: state_next.fastReg = regReq.wdata[FAST_BIT];
                OFS_PROGRAM_WAIT: begin
                    state_next.waitIe = regReq.wdata[WAIT_IE_BIT];
                    // writing one to the flag bit clears a wait that a completed column has set
                    if (regReq.wdata[WAIT_FLAG_BIT] && state_reg.waitFlag) begin
                        state_next.waitFlag = 1'b0;
                    end
                end
                default: begin
                    // unused half must be loaded with 0xff by software for half width
                    if (regReq.addr[REG_AW-1:2] == OFS_DATA0[REG_AW-1:2]) begin
                        state_next.rowData[regReq.addr[1:0]] = regReq.wdata;
                    end
                end
            endcase
        end

        // trigger byte write starts one column program
        if (trigWrite) begin
            blocked = !pgmAllowed;
            state_next.pgmBusy = !blocked;
            state_next.waitFlag = 1'b0;
            state_next.arr.pgmStart = !blocked;
            state_next.arr.pgmCol = curCol;
            state_next.arr.pgmInfo = state_reg.cmd[3];
            state_next.arr.pgmHalf = state_reg.half;
            state_next.arr.pgmData = {regReq.wdata, state_reg.rowData[2],
                state_reg.rowData[1], state_reg.rowData[0]};
        end

        // column completion; set wins over any clear in this cycle
        if (colDone || blocked) begin
            state_next.pgmBusy = 1'b0;
            state_next.waitFlag = 1'b1;
            if (state_reg.col != LAST_COL) begin
                state_next.col = state_reg.col + 5'h01;
            end else if (!state_reg.half) begin
                state_next.exec = 1'b0;
            end
        end

        // erase permission for the neighbouring erase sequencer
        if (eraseReq) begin
            if (eraseInfo ? !protLevel2 : (!protLevel2 || codeInFlash)) begin
                state_next.grant = 1'b1;
            end else begin
                state_next.refuse = 1'b1;
            end
        end

        // new timing takes effect between accesses only
        if (state_reg.st == FF_IDLE) begin
            state_next.fastMode = state_reg.fastReg;
        end

        unique case (state_reg.st)
            FF_IDLE: begin
                if (state_reg.exec && isReadCmd) begin
                    state_next.kind = FK_ROWRD;
                    state_next.st = FF_ACC;
                    state_next.arr.rdCol = curCol;
                    state_next.arr.rdInfo = state_reg.cmd[3];
                end else if (fetchReq.req) begin
                    if (fetchReq.isData ? dbHit : (ibHit0 || ibHit1)) begin
                        deliver = 1'b1;
                        dOfs = reqOfs;
                        dCol = reqCol;
                        if (fetchReq.isData) begin
                            state_next.outByte = pickByte(state_reg.dbData, reqOfs);
                        end else begin
                            state_next.outByte = pickByte(ibHit0 ? state_reg.ibData[0] :
                                state_reg.ibData[1], reqOfs);
                            state_next.ibLru = ibHit0;
                        end
                    end else begin
                        // a jump past a queued prefetch drops it and stalls
                        state_next.pfPending = 1'b0;
                        state_next.kind = fetchReq.isData ? FK_DATA : FK_INSTR;
                        state_next.reqAddr = fetchReq.addr;
                        state_next.st = FF_ACC;
                        state_next.arr.rdCol = reqCol;
                        state_next.arr.rdInfo = 1'b0;
                    end
                end else if (state_reg.pfPending) begin
                    state_next.kind = FK_PREF;
                    state_next.st = FF_ACC;
                    state_next.arr.rdCol = state_reg.pfTag;
                    state_next.arr.rdInfo = 1'b0;
                end
                if (state_next.st == FF_ACC) begin
                    state_next.arr.rdEn = 1'b1;
                    state_next.cnt = state_reg.fastReg ? ACC_FAST : ACC_SLOW;
                end
            end
            FF_ACC: begin
                // hold read enable for one or two cycles
                if (state_reg.cnt == ACC_SLOW) begin
                    state_next.arr.rdEn = 1'b0;
                    state_next.st = FF_CAP;
                end else begin
                    state_next.cnt = state_reg.cnt - 2'h1;
                end
            end
            FF_CAP: begin
                state_next.st = FF_IDLE;
                unique case (state_reg.kind)
                    FK_ROWRD: begin
                        state_next.rowData = arrayRdData;
                        state_next.exec = 1'b0;
                        if (state_reg.col != LAST_COL) begin
                            state_next.col = state_reg.col + 5'h01;
                        end
                    end
                    FK_DATA: begin
                        state_next.dbValid = 1'b1;
                        state_next.dbTag = state_reg.arr.rdCol;
                        state_next.dbData = arrayRdData;
                        state_next.outByte = pickByte(arrayRdData, state_reg.reqAddr[1:0]);
                        deliver = 1'b1;
                    end
                    default: begin
                        // fill the least recent line, instruction or prefetch alike
                        state_next.ibValid[state_reg.ibLru] = 1'b1;
                        state_next.ibTag[state_reg.ibLru] = state_reg.arr.rdCol;
                        state_next.ibData[state_reg.ibLru] = arrayRdData;
                        state_next.ibLru = !state_reg.ibLru;
                        if (state_reg.kind == FK_PREF) begin
                            state_next.pfPending = 1'b0;
                        end else begin
                            state_next.outByte = pickByte(arrayRdData, state_reg.reqAddr[1:0]);
                            deliver = 1'b1;
                            dOfs = state_reg.reqAddr[1:0];
                            dCol = state_reg.arr.rdCol;
                        end
                    end
                endcase
            end
            default: state_next.st = FF_IDLE;
        endcase

        // answer the cpu and decide on a sequential prefetch
        if (deliver) begin
            state_next.valid = 1'b1;
            // a hit in idle has not touched kind, so the answer's source decides
            instrAns = (state_reg.st == FF_IDLE) ? !fetchReq.isData
                : (state_reg.kind != FK_DATA);
            if (instrAns) begin
                prefOk = (dOfs == PF_OFS_SLOW) || (state_reg.fastMode && dOfs == PF_OFS_FAST);
                nextCol = dCol + 13'h0001;
                if (prefOk && !(state_next.ibValid[0] && state_next.ibTag[0] == nextCol)
                    && !(state_next.ibValid[1] && state_next.ibTag[1] == nextCol)) begin
                    state_next.pfPending = 1'b1;
                    state_next.pfTag = nextCol;
                end
            end
        end

        // stale columns must never be served after the array changes
        if (colDone || eraseDone) begin
            state_next.ibValid = 2'h0;
            state_next.dbValid = 1'b0;
            state_next.pfPending = 1'b0;
        end

        // register read data, reserved bits zero
        state_next.rdData = 8'h00;
        if (regReq.rd) begin
            unique case (regReq.addr)
                OFS_PAGE: state_next.rdData = {3'h0, state_reg.page};
                OFS_ROW: state_next.rdData = {5'h00, state_reg.row};
                OFS_COL: state_next.rdData = {3'h0, state_reg.col};
                OFS_MODE: state_next.rdData = {3'h0, state_reg.half, state_reg.cmd};
                OFS_EXEC: state_next.rdData = {7'h00, state_reg.exec};
                OFS_READ_TIMING: state_next.rdData = {7'h00, state_reg.fastReg};
                OFS_PROGRAM_WAIT: state_next.rdData = {3'h0, state_reg.waitFlag, 3'h0,
                    state_reg.waitIe};
                default: begin
                    if (regReq.addr[REG_AW-1:2] == OFS_DATA0[REG_AW-1:2]) begin
                        state_next.rdData = state_reg.rowData[regReq.addr[1:0]];
                    end
                end
            endcase
        end

        // a queued prefetch alone does not stall; a request then still wins
        state_next.busy = (state_next.st != FF_IDLE);
        state_next.irq = state_next.waitFlag && state_next.waitIe;
    end

    // single state register, synchronous active-low reset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            // outputs come up low, read timing comes up in two-cycle mode
            state_reg <= '0;
            state_reg.st <= FF_IDLE;
            state_reg.kind <= FK_INSTR;
            state_reg.fastReg <= FAST_RESET;
            state_reg.fastMode <= FAST_RESET;
            state_reg.rowData <= {4{DATA_RESET}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign regRdData = state_reg.rdData;
    assign fetchBusy = state_reg.busy;
    assign fetchValid = state_reg.valid;
    assign fetchByte = state_reg.outByte;
    assign arrayOut = state_reg.arr;
    assign eraseGrant = state_reg.grant;
    assign eraseRefused = state_reg.refuse;
    assign columnWaitIrq = state_reg.irq;
endmodule
`default_nettype wire

// ==== verif/ffpc_array_model.sv ====
// behavioural flash array behind the controller: column reads and column programs
// assumes read enable and program start come from the controller on clk
`timescale 1ns/1ns
`default_nettype none
module ffpc_array_model
    import ffpc_pkg::*;
#(
    parameter int PGM_LAT = 6
)(
    input wire logic clk,
    input wire ffpc_array_out_t arrayOut,
    output logic [31:0] arrayRdData,
    output logic arrayPgmDone
);
    logic [31:0] mem [logic [13:0]];
    int pgmCnt = 0;
    // unprogrammed columns carry a pattern made from their own index
    function automatic logic [31:0] word(input logic [13:0] idx);
        return mem.exists(idx) ? mem[idx] : {2'h0, idx, 2'h3, idx};
    endfunction
    initial begin
        arrayRdData = 32'h0;
        arrayPgmDone = 1'b0;
    end
    // outside a read the data toggles, so a capture one cycle late sees the inverted word
    always @(posedge clk) begin
        arrayRdData <= arrayOut.rdEn ? word({arrayOut.rdInfo, arrayOut.rdCol}) : ~arrayRdData;
        arrayPgmDone <= (pgmCnt == 1);
        if (pgmCnt > 0) pgmCnt <= pgmCnt - 1;
        if (arrayOut.pgmStart) begin
            mem[{arrayOut.pgmInfo, arrayOut.pgmCol}] = arrayOut.pgmData;
            pgmCnt <= PGM_LAT;
        end
    end
endmodule
`default_nettype wire

// ==== verif/ffpc_asserts.sv ====
// port checker for the flash fetch and program controller
// assumes one clock and the synchronous active-low reset of the design
`timescale 1ns/1ns
`default_nettype none
module ffpc_asserts
    import ffpc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire ffpc_reg_req_t regReq,
    input wire logic [7:0] regRdData,
    input wire logic fetchBusy,
    input wire ffpc_array_out_t arrayOut,
    input wire logic protLevel2,
    input wire logic codeInFlash,
    input wire logic eraseReq,
    input wire logic eraseInfo,
    input wire logic eraseGrant,
    input wire logic eraseRefused,
    input wire logic columnWaitIrq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // a miss stalls the cpu two cycles in one-cycle timing (enable, capture) and three in two-cycle timing (two enables, capture); the first two are checked
    sequence s_stall;
        fetchBusy [*2];
    endsequence
    sequence s_done;
        ##1 !fetchBusy;
    endsequence
    property p_rd_idle;
        !$past(regReq.rd) |-> regRdData == 8'h00;
    endproperty
    property p_rd_timing;
        $past(regReq.rd) && $past(regReq.addr) == OFS_READ_TIMING |-> regRdData[7:1] == 7'h00;
    endproperty
    property p_rden_len;
        $rose(arrayOut.rdEn) |-> ##[1:2] !arrayOut.rdEn;
    endproperty
    property p_stall;
        $rose(arrayOut.rdEn) |-> s_stall;
    endproperty
    property p_end;
        $fell(arrayOut.rdEn) |-> s_done;
    endproperty
    property p_pgm_pulse;
        arrayOut.pgmStart |=> !arrayOut.pgmStart;
    endproperty
    property p_pgm_irq;
        arrayOut.pgmStart |=> !columnWaitIrq;
    endproperty
    property p_ie_off;
        regReq.wr && regReq.addr == OFS_PROGRAM_WAIT && !regReq.wdata[WAIT_IE_BIT] |=> !columnWaitIrq;
    endproperty
    property p_erase_ok;
        eraseReq && !protLevel2 |=> eraseGrant && !eraseRefused;
    endproperty
    property p_erase_l2;
        eraseReq && protLevel2 && (eraseInfo || !codeInFlash) |=> eraseRefused && !eraseGrant;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    a_rd_timing: assert property (p_rd_timing) else $error("timing reserved bits set");
    a_rden_len: assert property (p_rden_len) else $error("read enable too long");
    a_stall: assert property (p_stall) else $error("no stall during array read");
    a_end: assert property (p_end) else $error("stall not ended after capture");
    a_pgm_pulse: assert property (p_pgm_pulse) else $error("program start too long");
    a_pgm_irq: assert property (p_pgm_irq) else $error("wait request during program");
    a_ie_off: assert property (p_ie_off) else $error("request while disabled");
    a_erase_ok: assert property (p_erase_ok) else $error("level one erase refused");
    a_erase_l2: assert property (p_erase_l2) else $error("level two erase granted");
endmodule
bind flash_fetch_program_ctrl ffpc_asserts u_ffpc_asserts (.clk, .resetn, .regReq, .regRdData,
    .fetchBusy, .arrayOut, .protLevel2, .codeInFlash, .eraseReq, .eraseInfo, .eraseGrant,
    .eraseRefused, .columnWaitIrq);
`default_nettype wire

// ==== verif/test_flash_fetch_program_ctrl.sv ====
// bench: register port, cpu fetches in both timing modes, column program, erase checks
// assumes the array model stands behind the controller on the same clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin fails++; \
    $display("unexpected %0t %s", $time, m); end end
module test_flash_fetch_program_ctrl
    import ffpc_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    ffpc_reg_req_t regReq = '0;
    ffpc_fetch_req_t fetchReq = '0;
    logic protLevel2 = 1'b0, codeInFlash = 1'b0, eraseReq = 1'b0;
    logic eraseInfo = 1'b0, eraseDone = 1'b0, rdLast = 1'b0;
    logic [7:0] regRdData, fetchByte;
    logic fetchBusy, fetchValid, eraseGrant, eraseRefused, columnWaitIrq, arrayPgmDone;
    ffpc_array_out_t arrayOut;
    logic [31:0] arrayRdData;
    logic [31:0] progWord = 32'h5ac3e17b;
    logic [13:0] progIdx = 14'h3fff;
    logic [14:0] a;
    logic [7:0] regQ[$], fetchQ[$];
    int fails = 0, check_count = 0, seed = 61252, lat;
    always #2 clk = ~clk;
    flash_fetch_program_ctrl uut (.clk, .resetn, .regReq, .regRdData, .fetchReq, .fetchBusy,
        .fetchValid, .fetchByte, .arrayOut, .arrayRdData, .arrayPgmDone, .protLevel2,
        .codeInFlash, .eraseReq, .eraseInfo, .eraseDone, .eraseGrant, .eraseRefused,
        .columnWaitIrq);
    ffpc_array_model u_array (.clk, .arrayOut, .arrayRdData, .arrayPgmDone);
    function automatic logic [7:0] exp_byte(input logic [14:0] ad);
        logic [31:0] w;
        w = ({1'b0, ad[14:2]} == progIdx) ? progWord : {3'h0, ad[14:2], 3'h6, ad[14:2]};
        return w[8 * ad[1:0] +: 8];
    endfunction
    // one register access; for a read d is the expected value
    task automatic reg_op(input logic w, input logic [15:0] ad, input logic [7:0] d);
        if (!w) regQ.push_back(d);
        regReq <= '{addr: ad, wdata: w ? d : 8'h00, wr: w, rd: !w};
        @(posedge clk);
        regReq <= '0;
        @(posedge clk);
    endtask
    // request held until taken while idle; latency counted from the taking edge
    task automatic fetch(input logic dat, input logic [14:0] ad, input int expLat);
        fetchQ.push_back(exp_byte(ad));
        fetchReq <= '{req: 1'b1, isData: dat, addr: ad};
        do @(posedge clk); while (fetchBusy);
        fetchReq <= '0;
        lat = 0;
        do begin @(negedge clk); lat++; end while (!fetchValid && lat < 20);
        `CHK(lat, expLat, "fetch latency")
        @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // answers are compared with the oldest note once settled
    always @(posedge clk) rdLast <= regReq.rd;
    always @(negedge clk) begin
        if (rdLast) `CHK(regRdData, regQ.pop_front(), "register read")
        if (fetchValid) `CHK(fetchByte, fetchQ.pop_front(), "fetch byte")
    end
    // hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #40000;
        fails++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        reg_op(0, OFS_READ_TIMING, {7'h00, FAST_RESET});
        reg_op(0, OFS_PROGRAM_WAIT, 8'h00);
        reg_op(0, OFS_DATA3, DATA_RESET);
        reg_op(0, 16'hff30, 8'h00);
        reg_op(1, OFS_READ_TIMING, 8'h00);
        reg_op(0, OFS_READ_TIMING, 8'h00);
        reg_op(1, OFS_PROGRAM_WAIT, 8'h11);
        reg_op(0, OFS_PROGRAM_WAIT, 8'h01);
        $display("register test done");
        fetch(0, 15'h0100, 3);
        fetch(0, 15'h0101, 1);
        fetch(0, 15'h0102, 1);
        fetch(0, 15'h0104, 3);
        fetch(0, 15'h0107, 1);
        fetch(0, 15'h0108, 1);
        fetch(0, 15'h0105, 1);
        fetch(0, 15'h010b, 1);
        fetch(0, 15'h2000, 3);
        $display("slow fetch test done");
        reg_op(1, OFS_READ_TIMING, 8'h01);
        fetch(0, 15'h3000, 4);
        fetch(0, 15'h3002, 1);
        fetch(0, 15'h3004, 1);
        for (int i = 0; i < 3; i++) begin
            a = 15'($random(seed));
            fetch(1, a, 4);
            fetch(1, a ^ 15'h0003, 1);
        end
        fetch(0, 15'h0400, 4);
        $display("fast fetch test done");
        reg_op(1, OFS_PAGE, 8'h01);
        reg_op(1, OFS_ROW, 8'h00);
        reg_op(1, OFS_COL, 8'h00);
        reg_op(1, OFS_MODE, {4'h0, CMD_PGM_MAIN});
        reg_op(1, OFS_EXEC, 8'h01);
        progIdx = 14'd256;
        for (int i = 0; i < 4; i++) reg_op(1, OFS_DATA0 + 16'(i), progWord[8 * i +: 8]);
        lat = 0;
        while (!columnWaitIrq && lat < 100) begin @(posedge clk); lat++; end
        `CHK(columnWaitIrq, 1'b1, "no wait request")
        reg_op(0, OFS_COL, 8'h01);
        reg_op(0, OFS_PROGRAM_WAIT, 8'h11);
        reg_op(1, OFS_PROGRAM_WAIT, 8'h11);
        reg_op(0, OFS_PROGRAM_WAIT, 8'h01);
        reg_op(1, OFS_EXEC, 8'h00);
        reg_op(0, OFS_EXEC, 8'h00);
        reg_op(1, OFS_MODE, {4'h0, CMD_NORMAL});
        reg_op(1, OFS_PROGRAM_WAIT, 8'h00);
        fetch(0, 15'h0403, 4);
        reg_op(1, OFS_PAGE, 8'h00);
        reg_op(1, OFS_ROW, {5'h00, PROT_CODE_ADDR[9:7]});
        reg_op(1, OFS_COL, {3'h0, PROT_CODE_ADDR[6:2]});
        reg_op(1, OFS_MODE, {4'h1, CMD_PGM_INFO});
        reg_op(1, OFS_EXEC, 8'h01);
        for (int i = 0; i < 4; i++)
            reg_op(1, OFS_DATA0 + 16'(i), i < 2 ? 8'hff : progWord[8 * i +: 8]);
        repeat (12) @(posedge clk);
        reg_op(0, OFS_PROGRAM_WAIT, 8'h10);
        reg_op(1, OFS_EXEC, 8'h00);
        reg_op(1, OFS_COL, 8'h00);
        reg_op(1, OFS_MODE, {4'h0, CMD_READ_INFO});
        reg_op(1, OFS_EXEC, 8'h01);
        repeat (6) @(posedge clk);
        for (int i = 0; i < 4; i++)
            reg_op(0, OFS_DATA0 + 16'(i), i < 2 ? 8'hff : progWord[8 * i +: 8]);
        $display("program test done");
        for (int i = 0; i < 8; i++) begin
            {protLevel2, eraseInfo, codeInFlash} <= 3'(i);
            eraseReq <= 1'b1;
            @(posedge clk);
            eraseReq <= 1'b0;
            @(negedge clk);
            `CHK(eraseRefused, i[2] & (i[1] | ~i[0]), "erase refusal")
            `CHK(eraseGrant, ~(i[2] & (i[1] | ~i[0])), "erase grant")
            @(posedge clk);
        end
        eraseDone <= 1'b1;
        @(posedge clk);
        eraseDone <= 1'b0;
        @(posedge clk);
        fetch(0, 15'h0401, 4);
        $display("erase test done");
        test_done();
    end
endmodule
`default_nettype wire
